// *** design/synth_config_pkg.sv ***
/*
  Shared constants and types for the spread-spectrum configuration registers.
  Assumes an SMBus protocol engine outside that turns bus traffic into byte accesses.
*/
package synth_config_pkg;

  localparam logic [7:0] PLL_CONTROL_OFFSET              = 8'h03;
  localparam logic [7:0] INPUT_SELECT_OFFSET             = 8'h0A;
  localparam logic [7:0] INPUT_SOURCE_OFFSET             = 8'h0B;
  localparam logic [7:0] SPREAD_SPECTRUM_SETTINGS_OFFSET = 8'h19;
  localparam logic [7:0] BLOCK_READ_LENGTH_OFFSET        = 8'h1A;

  localparam int SECOND_SYNTH_LOOP_BYPASS_BIT = 6;
  localparam int CLOCK_SELECT_BIT             = 4;
  localparam int INPUT_SOURCE_LSB             = 6;
  localparam int SPREAD_AMOUNT_LSB            = 4;
  localparam int SPREAD_RATE_LSB              = 0;

  localparam logic       SECOND_SYNTH_LOOP_BYPASS_RESET = 1'h0;
  localparam logic       CLOCK_SELECT_RESET             = 1'h0;
  localparam logic [1:0] INPUT_SOURCE_RESET             = 2'h0;
  localparam logic [3:0] SPREAD_RATE_RESET              = 4'h9;
  localparam logic [2:0] SPREAD_AMOUNT_RESET            = 3'h0;
  localparam logic [6:0] BLOCK_READ_LENGTH_RESET        = 7'h1B;
  localparam logic [6:0] BLOCK_READ_LENGTH_ZERO         = 7'h00;

  localparam logic [12:0] SPREAD_RATE_FACTOR_TABLE [16] = '{
    13'h1630, 13'h1524, 13'h1418, 13'h130C, 13'h1200, 13'h10F4, 13'h0FE8, 13'h0EDC,
    13'h0DD0, 13'h0CD6, 13'h0BB8, 13'h0AAC, 13'h09A0, 13'h0894, 13'h0788, 13'h067C
  };

  // Spread amount in hundredths of a percent
  localparam logic [8:0] SPREAD_AMOUNT_TABLE [8] = '{
    9'h000, 9'h00A, 9'h019, 9'h028, 9'h064, 9'h096, 9'h0C8, 9'h12C
  };

  typedef enum logic [1:0] {SPREAD_BYPASS, SPREAD_CENTER, SPREAD_DOWN} spread_mode_t;

  typedef enum logic [1:0] {
    INPUT_CRYSTAL, INPUT_SINGLE_ENDED, INPUT_DIFFERENTIAL, INPUT_RESERVED
  } input_mode_t;

  typedef enum logic {BLOCK_IDLE, BLOCK_SEND} block_state_t;

  typedef struct packed {
    logic       write;
    logic       read;
    logic [7:0] offset;
    logic [7:0] data;
  } reg_access_t;

  typedef struct packed {
    logic       valid;
    logic [7:0] data;
  } reg_answer_t;

  typedef struct packed {
    logic       valid;
    logic       last;
    logic [7:0] data;
  } block_byte_t;

  typedef struct packed {
    spread_mode_t mode;
    logic [8:0]   amount_hundredths;
    logic [12:0]  rate_factor;
    logic         power_down;
    logic         output_hold_low;
    logic         unmodulated_enable;
  } spread_config_t;

  typedef struct packed {
    input_mode_t mode;
    logic        use_clock_input_b;
  } input_config_t;

endpackage : synth_config_pkg

// *** design/spread_spectrum_config_regs.sv ***
/*
  Configuration register slice: spread settings of the second synthesis loop,
  block-read length and input clock source.
  Assumes byte accesses and block-read byte requests come from an SMBus engine,
  synchronous to clock.
*/
`timescale 1ns/1ps

//Contract
// - The 4-bit rate code decodes to factors 5680 down to 1660, default factor 3286.
// - The 3-bit amount decodes to bypass, three center spreads and four down spreads.
// - Amount bypass powers down the spread circuitry and holds the spread output low.
// - Amount bypass leaves the unmodulated output of the second loop running.
// - The block-read length is 7 bits, 1 to 127, and zero is never taken.
// - A block read returns exactly the programmed number of bytes, default 27.
// - The input clock mode comes from bits 7 to 6 of byte 11, crystal by default.
// - Input source codes are crystal, single-ended pair, differential and reserved.
module spread_spectrum_config_regs (
  input  wire logic                          clock,
  input  wire logic                          reset_n,
  input  wire synth_config_pkg::reg_access_t access,
  output synth_config_pkg::reg_answer_t      answer,
  input  wire logic                          block_read_start,
  input  wire logic                          byte_request,
  output synth_config_pkg::block_byte_t      block_byte,
  output logic                               block_read_busy,
  output logic [6:0]                         block_read_count,
  output logic                               second_synth_loop_bypass,
  output synth_config_pkg::spread_config_t   spread_config,
  output synth_config_pkg::input_config_t    input_config
);

  logic                           bypass_bit;
  logic                           clock_select_b;
  logic [1:0]                     input_source;
  logic [3:0]                     spread_rate_factor;
  logic [2:0]                     spread_amount;
  logic [6:0]                     block_read_length;
  synth_config_pkg::block_state_t block_state;
  logic [7:0]                     block_index;
  logic [6:0]                     block_remaining;

  function automatic logic [7:0] read_byte(input logic [7:0] offset);
    logic [7:0] value;
    value = 8'h00;
    if (offset == synth_config_pkg::PLL_CONTROL_OFFSET)
    begin
      value[synth_config_pkg::SECOND_SYNTH_LOOP_BYPASS_BIT] = bypass_bit;
    end
    else if (offset == synth_config_pkg::INPUT_SELECT_OFFSET)
    begin
      value[synth_config_pkg::CLOCK_SELECT_BIT] = clock_select_b;
    end
    else if (offset == synth_config_pkg::INPUT_SOURCE_OFFSET)
    begin
      value[synth_config_pkg::INPUT_SOURCE_LSB +: 2] = input_source;
    end
    else if (offset == synth_config_pkg::SPREAD_SPECTRUM_SETTINGS_OFFSET)
    begin
      value[synth_config_pkg::SPREAD_AMOUNT_LSB +: 3] = spread_amount;
      value[synth_config_pkg::SPREAD_RATE_LSB +: 4]   = spread_rate_factor;
    end
    else if (offset == synth_config_pkg::BLOCK_READ_LENGTH_OFFSET)
    begin
      value[6:0] = block_read_length;
    end
    return value;
  endfunction : read_byte

  // Register writes
  always_ff @(posedge clock)
  begin
    if (!reset_n)
    begin
      bypass_bit         <= synth_config_pkg::SECOND_SYNTH_LOOP_BYPASS_RESET;
      clock_select_b     <= synth_config_pkg::CLOCK_SELECT_RESET;
      input_source       <= synth_config_pkg::INPUT_SOURCE_RESET;
      spread_rate_factor <= synth_config_pkg::SPREAD_RATE_RESET;
      spread_amount      <= synth_config_pkg::SPREAD_AMOUNT_RESET;
      block_read_length  <= synth_config_pkg::BLOCK_READ_LENGTH_RESET;
    end
    else if (access.write)
    begin
      if (access.offset == synth_config_pkg::PLL_CONTROL_OFFSET)
      begin
        bypass_bit <= access.data[synth_config_pkg::SECOND_SYNTH_LOOP_BYPASS_BIT];
      end
      else if (access.offset == synth_config_pkg::INPUT_SELECT_OFFSET)
      begin
        clock_select_b <= access.data[synth_config_pkg::CLOCK_SELECT_BIT];
      end
      else if (access.offset == synth_config_pkg::INPUT_SOURCE_OFFSET)
      begin
        input_source <= access.data[synth_config_pkg::INPUT_SOURCE_LSB +: 2];
      end
      else if (access.offset == synth_config_pkg::SPREAD_SPECTRUM_SETTINGS_OFFSET)
      begin
        spread_amount      <= access.data[synth_config_pkg::SPREAD_AMOUNT_LSB +: 3];
        spread_rate_factor <= access.data[synth_config_pkg::SPREAD_RATE_LSB +: 4];
      end
      // Zero length refused, old count kept
      else if (access.offset == synth_config_pkg::BLOCK_READ_LENGTH_OFFSET &&
               access.data[6:0] != synth_config_pkg::BLOCK_READ_LENGTH_ZERO)
      begin
        block_read_length <= access.data[6:0];
      end
    end
  end

  // Single byte reads
  always_ff @(posedge clock)
  begin
    if (!reset_n)
    begin
      answer <= '0;
    end
    else
    begin
      answer.valid <= access.read;
      answer.data  <= access.read ? read_byte(access.offset) : 8'h00;
    end
  end

  // Block read sequencer
  always_ff @(posedge clock)
  begin
    if (!reset_n)
    begin
      block_state     <= synth_config_pkg::BLOCK_IDLE;
      block_index     <= 8'h00;
      block_remaining <= 7'h00;
      block_byte      <= '0;
      block_read_busy <= 1'b0;
    end
    // Start wins over a byte request
    else if (block_read_start)
    begin
      block_state     <= synth_config_pkg::BLOCK_SEND;
      block_index     <= 8'h00;
      block_remaining <= block_read_length;
      block_byte      <= '0;
      block_read_busy <= 1'b1;
    end
    else
    begin
      block_byte <= '0;
      case (block_state)
        synth_config_pkg::BLOCK_IDLE:
        begin
          block_read_busy <= 1'b0;
        end
        synth_config_pkg::BLOCK_SEND:
        begin
          if (byte_request)
          begin
            block_byte.valid <= 1'b1;
            block_byte.last  <= (block_remaining == 7'h01);
            block_byte.data  <= read_byte(block_index);
            block_index      <= block_index + 8'h01;
            block_remaining  <= block_remaining - 7'h01;
            if (block_remaining == 7'h01)
            begin
              block_state     <= synth_config_pkg::BLOCK_IDLE;
              block_read_busy <= 1'b0;
            end
          end
        end
        default:
        begin
          block_state <= synth_config_pkg::BLOCK_IDLE;
        end
      endcase
    end
  end

  // Decoded configuration
  // Decode lags the registers by one clock
  always_ff @(posedge clock)
  begin
    if (!reset_n)
    begin
      block_read_count         <= synth_config_pkg::BLOCK_READ_LENGTH_RESET;
      second_synth_loop_bypass <= synth_config_pkg::SECOND_SYNTH_LOOP_BYPASS_RESET;
      spread_config.mode       <= synth_config_pkg::SPREAD_BYPASS;
      spread_config.amount_hundredths <=
        synth_config_pkg::SPREAD_AMOUNT_TABLE[synth_config_pkg::SPREAD_AMOUNT_RESET];
      spread_config.rate_factor <=
        synth_config_pkg::SPREAD_RATE_FACTOR_TABLE[synth_config_pkg::SPREAD_RATE_RESET];
      spread_config.power_down         <= 1'b1;
      spread_config.output_hold_low    <= 1'b1;
      spread_config.unmodulated_enable <= 1'b1;
      input_config.mode                <= synth_config_pkg::INPUT_CRYSTAL;
      input_config.use_clock_input_b   <= 1'b0;
    end
    else
    begin
      block_read_count         <= block_read_length;
      second_synth_loop_bypass <= bypass_bit;
      if (spread_amount == 3'h0)
        spread_config.mode <= synth_config_pkg::SPREAD_BYPASS;
      else if (!spread_amount[2])
        spread_config.mode <= synth_config_pkg::SPREAD_CENTER;
      else
        spread_config.mode <= synth_config_pkg::SPREAD_DOWN;
      spread_config.amount_hundredths <=
        synth_config_pkg::SPREAD_AMOUNT_TABLE[spread_amount];
      spread_config.rate_factor <=
        synth_config_pkg::SPREAD_RATE_FACTOR_TABLE[spread_rate_factor];
      spread_config.power_down         <= (spread_amount == 3'h0);
      spread_config.output_hold_low    <= (spread_amount == 3'h0);
      spread_config.unmodulated_enable <= !bypass_bit;
      case (input_source)
        2'h0:    input_config.mode <= synth_config_pkg::INPUT_CRYSTAL;
        2'h1:    input_config.mode <= synth_config_pkg::INPUT_SINGLE_ENDED;
        2'h2:    input_config.mode <= synth_config_pkg::INPUT_DIFFERENTIAL;
        default: input_config.mode <= synth_config_pkg::INPUT_RESERVED;
      endcase
      input_config.use_clock_input_b <= (input_source == 2'h1) && clock_select_b;
    end
  end

endmodule : spread_spectrum_config_regs

// *** test/spread_spectrum_config_regs_monitor.sv ***
/* Checker for the configuration register slice.
   Bound to the top module; sees its ports only. */
`timescale 1ns/1ps
module spread_spectrum_config_regs_monitor (
  input wire logic                             clock,
  input wire logic                             reset_n,
  input wire synth_config_pkg::reg_access_t    access,
  input wire synth_config_pkg::reg_answer_t    answer,
  input wire logic                             block_read_start,
  input wire logic                             byte_request,
  input wire synth_config_pkg::block_byte_t    block_byte,
  input wire logic                             block_read_busy,
  input wire logic [6:0]                       block_read_count,
  input wire logic                             second_synth_loop_bypass,
  input wire synth_config_pkg::spread_config_t spread_config
);
  default clocking @(posedge clock); endclocking
  default disable iff (!reset_n);
  sequence s_req;
    block_read_busy && byte_request && !block_read_start;
  endsequence
  sequence s_idle_req;
    !block_read_busy && byte_request && !block_read_start;
  endsequence
  sequence s_len_wr;
    access.write && access.offset == synth_config_pkg::BLOCK_READ_LENGTH_OFFSET;
  endsequence
  property p_req; s_req |=> block_byte.valid; endproperty
  property p_idle; s_idle_req |=> !block_byte.valid; endproperty
  property p_start; block_read_start |=> block_read_busy; endproperty
  property p_last; block_byte.last |-> block_byte.valid && !block_read_busy; endproperty
  property p_nonzero; block_read_count != 7'h00; endproperty
  property p_zero; s_len_wr and access.data[6:0] == 7'h00 |=> $stable(block_read_count)[*2];
  endproperty
  property p_len; s_len_wr and access.data[6:0] != 7'h00
    |-> ##2 block_read_count == $past(access.data[6:0], 2); endproperty
  property p_power;
    spread_config.power_down == (spread_config.mode == synth_config_pkg::SPREAD_BYPASS)
    && spread_config.output_hold_low == spread_config.power_down;
  endproperty
  property p_unmod; (!second_synth_loop_bypass)[*2] |-> spread_config.unmodulated_enable;
  endproperty
  property p_read; access.read |=> answer.valid; endproperty
  property p_quiet; !access.read |=> answer == '0; endproperty
  a_req: assert property (p_req) else $error("no byte after request");
  a_idle: assert property (p_idle) else $error("byte while idle");
  a_start: assert property (p_start) else $error("not busy after start");
  a_last: assert property (p_last) else $error("busy after last");
  a_nonzero: assert property (p_nonzero) else $error("zero count");
  a_zero: assert property (p_zero) else $error("zero count taken");
  a_len: assert property (p_len) else $error("count not updated");
  a_power: assert property (p_power) else $error("bypass power wrong");
  a_unmod: assert property (p_unmod) else $error("unmodulated output off");
  a_read: assert property (p_read) else $error("no read answer");
  a_quiet: assert property (p_quiet) else $error("answer not idle");
endmodule : spread_spectrum_config_regs_monitor
bind spread_spectrum_config_regs spread_spectrum_config_regs_monitor
  i_spread_spectrum_config_regs_monitor (.clock, .reset_n, .access, .answer,
  .block_read_start, .byte_request, .block_byte, .block_read_busy, .block_read_count,
  .second_synth_loop_bypass, .spread_config);

// *** test/smbus_host_model.sv ***
/* Host side model issuing single byte accesses.
   Assumes the bench calls its tasks; drives at the falling edge. */
`timescale 1ns/1ps
module smbus_host_model (
  input  wire logic                          clock,
  input  wire synth_config_pkg::reg_answer_t answer,
  output synth_config_pkg::reg_access_t      access
);
  initial access = '0;
  task automatic write_byte(input logic [7:0] offset, input logic [7:0] data);
    @(negedge clock);
    access = '{1'b1, 1'b0, offset, data};
    @(negedge clock);
    access = '0;
  endtask : write_byte
  task automatic read_byte(input logic [7:0] offset, output logic [7:0] data);
    @(negedge clock);
    access = '{1'b0, 1'b1, offset, 8'h00};
    @(negedge clock);
    access = '0;
    data = answer.data;
  endtask : read_byte
  task automatic update_spread(input logic [7:0] value);
    write_byte(synth_config_pkg::PLL_CONTROL_OFFSET, 8'h40);
    write_byte(synth_config_pkg::SPREAD_SPECTRUM_SETTINGS_OFFSET, value);
    write_byte(synth_config_pkg::PLL_CONTROL_OFFSET, 8'h00);
  endtask : update_spread
endmodule : smbus_host_model

// *** test/spread_spectrum_config_regs_tb.sv ***
/* Bench for the configuration register slice.
   Host model issues byte accesses; block reads driven at the falling edge. */
`timescale 1ns/1ps
module spread_spectrum_config_regs_tb;
  logic                             clock;
  logic                             reset_n;
  logic                             block_read_start;
  logic                             byte_request;
  synth_config_pkg::reg_access_t    access;
  synth_config_pkg::reg_answer_t    answer;
  synth_config_pkg::block_byte_t    block_byte;
  logic                             block_read_busy;
  logic [6:0]                       block_read_count;
  logic                             second_synth_loop_bypass;
  synth_config_pkg::spread_config_t spread_config;
  synth_config_pkg::input_config_t  input_config;
  int                               miscompares;
  int                               n_checks;
  int                               seed;
  logic [7:0]                       d;
  logic [6:0]                       len;
  spread_spectrum_config_regs i_spread_spectrum_config_regs (.clock, .reset_n, .access,
    .answer, .block_read_start, .byte_request, .block_byte, .block_read_busy,
    .block_read_count, .second_synth_loop_bypass, .spread_config, .input_config);
  smbus_host_model i_smbus_host_model (.clock, .answer, .access);
  initial
  begin
    clock = 0;
    forever #50 clock = ~clock;
  end
  task automatic check(string name, logic [15:0] seen, logic [15:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask : check
  task automatic stop_test;
    $display("checks %0d miscompares %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : stop_test
  function automatic logic [12:0] rate_exp(logic [3:0] c);
    return (c == 4'h9) ? 13'h0CD6 : 13'h1630 - 13'h010C * c;
  endfunction : rate_exp
  function automatic logic [8:0] amt_exp(logic [2:0] a);
    logic [8:0] t [8] = '{9'h000, 9'h00A, 9'h019, 9'h028, 9'h064, 9'h096, 9'h0C8, 9'h12C};
    return t[a];
  endfunction : amt_exp
  function automatic logic [7:0] exp_block(int idx, logic [6:0] n);
    if (idx == synth_config_pkg::SPREAD_SPECTRUM_SETTINGS_OFFSET) return 8'h7F;
    if (idx == synth_config_pkg::BLOCK_READ_LENGTH_OFFSET) return {1'b0, n};
    return 8'h00;
  endfunction : exp_block
  task automatic block_read(input logic [6:0] n_exp);
    int n = 0;
    int k = 0;
    @(negedge clock) block_read_start = 1;
    @(negedge clock) block_read_start = 0;
    byte_request = 1;
    while (n < n_exp && k < 300)
    begin
      @(negedge clock) k++;
      if (block_byte.valid === 1'b1) n++;
      if (block_byte.valid === 1'b1) check("last", block_byte.last, n == n_exp);
      if (block_byte.valid === 1'b1) check("block data", block_byte.data, exp_block(n - 1, n_exp));
    end
    if (k >= 300) miscompares++;
    if (k >= 300) stop_test;
    check("busy", block_read_busy, 0);
    @(negedge clock) check("idle byte", block_byte.valid, 0);
    byte_request = 0;
  endtask : block_read
  initial
  begin
    seed = 25;
    miscompares = 0;
    n_checks = 0;
    reset_n = 0;
    block_read_start = 0;
    byte_request = 0;
    repeat (4) @(negedge clock);
    reset_n = 1;
    i_smbus_host_model.read_byte(8'h19, d);
    check("spread byte", d, 16'h0009);
    i_smbus_host_model.read_byte(8'h1A, d);
    check("length", d, 16'h001B);
    check("factor", spread_config.rate_factor, 16'h0CD6);
    check("input mode", input_config.mode, 16'h0000);
    for (int i = 0; i < 16; i++)
    begin
      i_smbus_host_model.update_spread({1'b0, i[2:0], i[3:0]});
      @(negedge clock);
      check("factor", spread_config.rate_factor, rate_exp(i[3:0]));
      check("amount", spread_config.amount_hundredths, amt_exp(i[2:0]));
      check("mode", spread_config.mode, i[2:0] == 0 ? 0 : (i[2] ? 2 : 1));
      check("power", spread_config.power_down, i[2:0] == 0);
      check("unmod", spread_config.unmodulated_enable, 1);
      check("hold low", spread_config.output_hold_low, i[2:0] == 0);
      check("bypass", second_synth_loop_bypass, 0);
    end
    i_smbus_host_model.write_byte(8'h1A, 8'h00);
    i_smbus_host_model.read_byte(8'h1A, d);
    check("zero length", d, 16'h001B);
    for (int j = 0; j < 3; j++)
    begin
      len = (j == 0) ? 7'h01 : (j == 1) ? 7'h7F : 7'($random(seed)) | 7'h01;
      i_smbus_host_model.write_byte(8'h1A, {1'b0, len});
      @(negedge clock) check("count", block_read_count, len);
      block_read(len);
    end
    i_smbus_host_model.write_byte(8'h0A, 8'h10);
    for (int c = 0; c < 4; c++)
    begin
      i_smbus_host_model.write_byte(8'h0B, {c[1:0], 6'h00});
      @(negedge clock) check("source", input_config.mode, c);
      check("select b", input_config.use_clock_input_b, c == 1);
    end
    @(negedge clock) reset_n = 0;
    repeat (2) @(negedge clock);
    reset_n = 1;
    check("reset count", block_read_count, 16'h001B);
    check("reset source", input_config.mode, 16'h0000);
    check("reset factor", spread_config.rate_factor, 16'h0CD6);
    i_smbus_host_model.write_byte(8'h30, 8'($random(seed)));
    i_smbus_host_model.read_byte(8'h30, d);
    check("unmapped", d, 16'h0000);
    stop_test;
  end
endmodule : spread_spectrum_config_regs_tb
